// [hdl/gpp_consts.svh]
/*
  Address map, reset values and sizes of the general purpose port block.
  Assumes an 8-bit I/O register space with a 6-bit address.
*/
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH

`define GPP_ADDR_W 6
`define GPP_DATA_W 8
`define GPP_NUM_PORTS 2

// Port A registers
`define GPP_ADDR_SENSE_A 6'h00
`define GPP_ADDR_DIRECTION_A 6'h01
`define GPP_ADDR_OUTPUT_A 6'h02
`define GPP_ADDR_PULLUP_A 6'h03
// Port B registers
`define GPP_ADDR_SENSE_B 6'h04
`define GPP_ADDR_DIRECTION_B 6'h05
`define GPP_ADDR_OUTPUT_B 6'h06
`define GPP_ADDR_PULLUP_B 6'h07

`define GPP_RST_DIRECTION 8'h00
`define GPP_RST_OUTPUT 8'h00
`define GPP_RST_PULLUP 8'h00
`define GPP_RST_RDATA 8'h00
`define GPP_RST_SYNC 8'h00

// Port B pins with alternate input control
`define GPP_PIN_B1 1
`define GPP_PIN_B2 2

`endif

// [hdl/gpp_pkg.sv]
/*
  Types of the general purpose port block.
  Assumes gpp_consts.svh on the include path.
*/
`include "gpp_consts.svh"

package gpp_pkg;

  typedef logic [`GPP_DATA_W-1:0] gpp_byte_t;
  typedef logic [`GPP_ADDR_W-1:0] gpp_addr_t;

  // Register kind selected by an I/O address, one-hot
  typedef enum logic [4:0] {
    GPP_SEL_NONE = 5'b00001,
    GPP_SEL_SENSE = 5'b00010,
    GPP_SEL_DIRECTION = 5'b00100,
    GPP_SEL_OUTPUT = 5'b01000,
    GPP_SEL_PULLUP = 5'b10000
  } gpp_sel_t;

endpackage

// [hdl/gpp_sync.sv]
/*
  Two-stage synchroniser for the eight pin levels of one port.
  Assumes the single I/O clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.svh"

module gpp_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire gpp_pkg::gpp_byte_t level_in,
  output gpp_pkg::gpp_byte_t level_out
);
  import gpp_pkg::*;

  gpp_byte_t meta_q;
  gpp_byte_t stable_q;

  // ==========================================================
  // Two flops
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_q <= `GPP_RST_SYNC;
      stable_q <= `GPP_RST_SYNC;
    end else begin
      meta_q <= level_in;
      stable_q <= meta_q;
    end
  end

  assign level_out = stable_q;

endmodule

`default_nettype wire

// [hdl/gpp_ports.sv]
/*
  Two 8-bit general purpose ports with direction, output value, pull-up
  and input sense bits on the I/O register space.
  Assumes one I/O clock, synchronous pads split into in/out/enable, and a
  processor that gives at most one register access per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gpp_consts.svh"

// How it works
// - Each pin has direction, output value, pull-up and sense bits.
// - Direction bit one makes the pin an output, zero an input.
// - Output pin drives high on value bit one, low on zero.
// - Input pin ignores value bit; pull-up follows only its enable bit.
// - Sense bit reads the pin level in any direction.
// - Writing one to a sense bit toggles the output value bit.
// - Pull-up enable bit set turns the pin pull-up on.
// - Strobes shared per port; clock and sleep shared by all ports.
// - Pin B1 input override from pin-change enable or analog disable.
// - Pin B2 input override likewise; other overrides stay inactive.
module gpp_ports (
  input wire logic clock,
  input wire logic rst_b,
  input wire gpp_pkg::gpp_addr_t io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire gpp_pkg::gpp_byte_t io_wdata,
  output gpp_pkg::gpp_byte_t io_rdata,
  input wire logic sleep,
  input wire gpp_pkg::gpp_byte_t pad_a_in,
  output gpp_pkg::gpp_byte_t pad_a_out,
  output gpp_pkg::gpp_byte_t pad_a_oe,
  output gpp_pkg::gpp_byte_t pullup_a,
  input wire gpp_pkg::gpp_byte_t pad_b_in,
  output gpp_pkg::gpp_byte_t pad_b_out,
  output gpp_pkg::gpp_byte_t pad_b_oe,
  output gpp_pkg::gpp_byte_t pullup_b,
  input wire logic pin_change_enable_b1,
  input wire logic pin_change_enable_b2,
  input wire logic pin_change_group_enable,
  input wire logic analog_digital_disable_b1,
  input wire logic analog_digital_disable_b2,
  output gpp_pkg::gpp_byte_t alt_in_a,
  output gpp_pkg::gpp_byte_t alt_in_b
);
  import gpp_pkg::*;

  // ==========================================================
  // Address decode

  function automatic gpp_sel_t sel_of(input gpp_addr_t addr);
    unique case (addr)
      `GPP_ADDR_SENSE_A, `GPP_ADDR_SENSE_B: sel_of = GPP_SEL_SENSE;
      `GPP_ADDR_DIRECTION_A, `GPP_ADDR_DIRECTION_B:
        sel_of = GPP_SEL_DIRECTION;
      `GPP_ADDR_OUTPUT_A, `GPP_ADDR_OUTPUT_B: sel_of = GPP_SEL_OUTPUT;
      `GPP_ADDR_PULLUP_A, `GPP_ADDR_PULLUP_B: sel_of = GPP_SEL_PULLUP;
      default: sel_of = GPP_SEL_NONE;
    endcase
  endfunction

  // Port index of an address: 0 for port A, 1 for port B
  function automatic logic port_of(input gpp_addr_t addr);
    port_of = (addr >= `GPP_ADDR_SENSE_B);
  endfunction

  gpp_sel_t sel;
  logic port_idx;
  logic [`GPP_NUM_PORTS-1:0] write_strobe_shared;
  logic [`GPP_NUM_PORTS-1:0] read_strobe_shared;

  assign sel = sel_of(io_addr);
  assign port_idx = port_of(io_addr);

  // One write and one read strobe per port, common to its pins
  always_comb begin
    write_strobe_shared = '0;
    read_strobe_shared = '0;
    write_strobe_shared[port_idx] = io_wr && (sel != GPP_SEL_NONE);
    read_strobe_shared[port_idx] = io_rd && (sel != GPP_SEL_NONE);
  end

  // ==========================================================
  // Per-pin storage

  gpp_byte_t direction_q [`GPP_NUM_PORTS];
  gpp_byte_t output_value_q [`GPP_NUM_PORTS];
  gpp_byte_t pullup_q [`GPP_NUM_PORTS];

  // Direction bits
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int p = 0; p < `GPP_NUM_PORTS; p++) begin
        direction_q[p] <= `GPP_RST_DIRECTION;
      end
    end else begin
      for (int p = 0; p < `GPP_NUM_PORTS; p++) begin
        if (write_strobe_shared[p] && sel == GPP_SEL_DIRECTION) begin
          direction_q[p] <= io_wdata;
        end
      end
    end
  end

  // Output value bits, written directly or toggled through sense
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int p = 0; p < `GPP_NUM_PORTS; p++) begin
        output_value_q[p] <= `GPP_RST_OUTPUT;
      end
    end else begin
      for (int p = 0; p < `GPP_NUM_PORTS; p++) begin
        if (write_strobe_shared[p] && sel == GPP_SEL_OUTPUT) begin
          output_value_q[p] <= io_wdata;
        end else if (write_strobe_shared[p] && sel == GPP_SEL_SENSE) begin
          output_value_q[p] <= output_value_q[p] ^ io_wdata;
        end
      end
    end
  end

  // Pull-up enable bits
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int p = 0; p < `GPP_NUM_PORTS; p++) begin
        pullup_q[p] <= `GPP_RST_PULLUP;
      end
    end else begin
      for (int p = 0; p < `GPP_NUM_PORTS; p++) begin
        if (write_strobe_shared[p] && sel == GPP_SEL_PULLUP) begin
          pullup_q[p] <= io_wdata;
        end
      end
    end
  end

  // ==========================================================
  // Pad drive

  assign pad_a_oe = direction_q[0];
  assign pad_b_oe = direction_q[1];
  // Value only reaches the pin while its enable is high
  assign pad_a_out = output_value_q[0];
  assign pad_b_out = output_value_q[1];
  assign pullup_a = pullup_q[0];
  assign pullup_b = pullup_q[1];

  // ==========================================================
  // Digital input enable

  logic b1_change_term;
  logic b2_change_term;
  logic b1_override_en;
  logic b2_override_en;
  gpp_byte_t in_enable_a;
  gpp_byte_t in_enable_b;

  assign b1_change_term = pin_change_enable_b1 && pin_change_group_enable;
  assign b2_change_term = pin_change_enable_b2 && pin_change_group_enable;
  assign b1_override_en = b1_change_term || analog_digital_disable_b1;
  assign b2_override_en = b2_change_term ||
    analog_digital_disable_b2;

  // Sleep gates every input buffer unless an override holds it
  always_comb begin
    in_enable_a = {`GPP_DATA_W{!sleep}};
    in_enable_b = {`GPP_DATA_W{!sleep}};
    if (b1_override_en) begin
      in_enable_b[`GPP_PIN_B1] = b1_change_term;
    end
    if (b2_override_en) begin
      in_enable_b[`GPP_PIN_B2] = b2_change_term;
    end
  end

  // ==========================================================
  // Input synchronisation

  gpp_byte_t sense_a;
  gpp_byte_t sense_b;

  gpp_sync u_sync_a (
    .clock(clock),
    .rst_b(rst_b),
    .level_in(pad_a_in & in_enable_a),
    .level_out(sense_a)
  );

  gpp_sync u_sync_b (
    .clock(clock),
    .rst_b(rst_b),
    .level_in(pad_b_in & in_enable_b),
    .level_out(sense_b)
  );

  assign alt_in_a = sense_a;
  assign alt_in_b = sense_b;

  // ==========================================================
  // Read data

  gpp_byte_t rdata_d;
  gpp_byte_t rdata_q;

  always_comb begin
    rdata_d = rdata_q;
    if (read_strobe_shared[port_idx]) begin
      unique case (sel)
        GPP_SEL_SENSE: rdata_d = port_idx ? sense_b : sense_a;
        GPP_SEL_DIRECTION: rdata_d = direction_q[port_idx];
        GPP_SEL_OUTPUT: rdata_d = output_value_q[port_idx];
        GPP_SEL_PULLUP: rdata_d = pullup_q[port_idx];
        GPP_SEL_NONE: rdata_d = `GPP_RST_RDATA;
      endcase
    end else if (io_rd) begin
      rdata_d = `GPP_RST_RDATA;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_q <= `GPP_RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign io_rdata = rdata_q;

endmodule

`default_nettype wire

// [verif/gpp_checker.sv]
/* Assertions on the port block's register bus and pins.
   Bound to gpp_ports; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module gpp_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire gpp_pkg::gpp_addr_t io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire gpp_pkg::gpp_byte_t io_wdata,
  input wire gpp_pkg::gpp_byte_t io_rdata,
  input wire logic sleep,
  input wire gpp_pkg::gpp_byte_t pad_a_in,
  input wire gpp_pkg::gpp_byte_t pad_a_oe,
  input wire gpp_pkg::gpp_byte_t pad_a_out,
  input wire gpp_pkg::gpp_byte_t pullup_a,
  input wire gpp_pkg::gpp_byte_t pad_b_out,
  input wire gpp_pkg::gpp_byte_t pad_b_oe,
  input wire gpp_pkg::gpp_byte_t alt_in_a
);
  import gpp_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Properties
  property p_dir;
    io_wr && io_addr == 6'h05 |=> pad_b_oe == $past(io_wdata);
  endproperty
  a_dir: assert property (p_dir) else $error("direction lost");
  property p_out;
    io_wr && io_addr == 6'h02 |=> pad_a_out == $past(io_wdata);
  endproperty
  a_out: assert property (p_out) else $error("value lost");
  property p_tog;
    io_wr && io_addr == 6'h04
      |=> pad_b_out == ($past(pad_b_out) ^ $past(io_wdata));
  endproperty
  a_tog: assert property (p_tog) else $error("toggle wrong");
  property p_pu;
    io_wr && io_addr == 6'h03 |=> pullup_a == $past(io_wdata);
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up lost");
  property p_iso;
    io_wr && io_addr == 6'h02 |=> $stable(pullup_a) && $stable(pad_a_oe);
  endproperty
  a_iso: assert property (p_iso) else $error("value leaks");
  property p_sync;
    !sleep [*3] ##0 ($past(rst_b) && $past(rst_b, 2))
      |-> alt_in_a == $past(pad_a_in, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync wrong");
  property p_rd;
    io_rd && !io_wr && io_addr == 6'h01 |=> io_rdata == $past(pad_a_oe);
  endproperty
  a_rd: assert property (p_rd) else $error("readback wrong");
  property p_bad;
    io_rd && io_addr > 6'h07 |=> io_rdata == 8'h00;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped read");
  cover property (io_wr && io_addr == 6'h04);
  cover property (sleep ##1 !sleep);
  cover property (io_rd && io_addr > 6'h07);
endmodule
bind gpp_ports gpp_checker chk_i (.clock, .rst_b, .io_addr, .io_wr, .io_rd,
  .io_wdata, .io_rdata, .sleep, .pad_a_in, .pad_a_oe, .pad_a_out, .pullup_a,
  .pad_b_out, .pad_b_oe, .alt_in_a);
`default_nettype wire

// [verif/gpp_pins_model.sv]
/* Board side of eight port pins: outside drivers, pull-ups, floating.
   Assumes the port's split value, enable and pull-up lines. */
`timescale 1ns/1ps
`default_nettype none
module gpp_pins_model (
  input wire logic clock,
  input wire gpp_pkg::gpp_byte_t drv,
  input wire gpp_pkg::gpp_byte_t oe,
  input wire gpp_pkg::gpp_byte_t pu,
  input wire gpp_pkg::gpp_byte_t ext,
  input wire gpp_pkg::gpp_byte_t ext_en,
  output gpp_pkg::gpp_byte_t level
);
  import gpp_pkg::*;
  gpp_byte_t fl_q = 8'h00;
  // ==========================================
  // Floating pins change every cycle
  always @(posedge clock) begin
    fl_q <= ~fl_q;
  end
  assign level = (oe & drv) | (~oe & ext_en & ext)
    | (~oe & ~ext_en & pu) | (~oe & ~ext_en & ~pu & fl_q);
endmodule
`default_nettype wire

// [verif/tb_top.sv]
/* Self-checking bench of the port block with pin models on both ports.
   Assumes gpp_ports, gpp_checker and gpp_pins_model compiled before. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpp_pkg::*;
  logic clock, rst_b, io_wr, io_rd, sleep, pc1, pc2, grp, ad1, ad2;
  gpp_addr_t io_addr;
  gpp_byte_t io_wdata, io_rdata, pad_a_in, pad_a_out, pad_a_oe, pullup_a;
  gpp_byte_t pad_b_in, pad_b_out, pad_b_oe, pullup_b, alt_in_a, alt_in_b;
  gpp_byte_t ext_a, en_a, ext_b, en_b, v, e;
  int i, failures, compares, cycles;
  gpp_ports uut (.clock, .rst_b, .io_addr, .io_wr, .io_rd, .io_wdata,
    .io_rdata, .sleep, .pad_a_in, .pad_a_out, .pad_a_oe, .pullup_a,
    .pad_b_in, .pad_b_out, .pad_b_oe, .pullup_b, .pin_change_enable_b1(pc1),
    .pin_change_enable_b2(pc2), .pin_change_group_enable(grp),
    .analog_digital_disable_b1(ad1), .analog_digital_disable_b2(ad2),
    .alt_in_a, .alt_in_b);
  gpp_pins_model pins_a (.clock, .drv(pad_a_out), .oe(pad_a_oe),
    .pu(pullup_a), .ext(ext_a), .ext_en(en_a), .level(pad_a_in));
  gpp_pins_model pins_b (.clock, .drv(pad_b_out), .oe(pad_b_oe),
    .pu(pullup_b), .ext(ext_b), .ext_en(en_b), .level(pad_b_in));
  // ==========================================
  // Bus and check tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input gpp_addr_t a, input gpp_byte_t d);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    cyc(1);
    io_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input gpp_addr_t a, output gpp_byte_t d);
    io_addr <= a;
    io_rd <= 1'b1;
    cyc(1);
    io_rd <= 1'b0;
    cyc(1);
    d = io_rdata;
  endtask
  task automatic chk(input gpp_byte_t s, input gpp_byte_t x);
    compares++;
    if (s !== x) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // Clock and timeout
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      report_and_stop;
    end
  end
  // ==========================================
  // Tests
  initial begin
    {rst_b, io_wr, io_rd, sleep, pc1, pc2, grp, ad1, ad2} = 9'h000;
    {io_addr, io_wdata, ext_a, ext_b} = 30'h0;
    {en_a, en_b, failures, compares, cycles} = {16'hffff, 96'h0};
    cyc(3);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(i[5:0], v);
      chk(v, 8'h00);
    end
    $display("reset test done");
    en_a <= 8'hf0;
    ext_a <= 8'haa;
    wr(6'h01, 8'h0f);
    wr(6'h02, 8'h35);
    wr(6'h03, 8'hc0);
    cyc(3);
    rd(6'h00, v);
    chk(v, 8'ha5);
    chk(pullup_a, 8'hc0);
    en_a <= 8'h30;
    wr(6'h02, 8'hf5);
    cyc(3);
    rd(6'h00, v);
    chk(v, 8'he5);
    $display("port a test done");
    wr(6'h05, 8'hff);
    wr(6'h06, 8'h0f);
    wr(6'h04, 8'h81);
    wr(6'h04, 8'h00);
    rd(6'h06, v);
    chk(v, 8'h8e);
    cyc(2);
    rd(6'h04, v);
    chk(v, 8'h8e);
    wr(6'h3f, 8'h00);
    rd(6'h3f, v);
    chk(v, 8'h00);
    chk(pad_b_oe, 8'hff);
    rd(6'h05, v);
    chk(v, 8'hff);
    wr(6'h07, 8'h3c);
    rd(6'h07, v);
    chk(v, 8'h3c);
    chk(pullup_b, 8'h3c);
    $display("toggle test done");
    wr(6'h05, 8'h00);
    ext_b <= 8'hff;
    for (i = 0; i < 64; i++) begin
      {sleep, ad2, ad1, grp, pc2, pc1} <= i[5:0];
      cyc(4);
      e = sleep ? 8'h00 : 8'hff;
      e[1] = ((pc1 & grp) | ad1) ? (pc1 & grp) : ~sleep;
      e[2] = ((pc2 & grp) | ad2) ? (pc2 & grp) : ~sleep;
      chk(alt_in_b, e);
      chk(alt_in_a, sleep ? 8'h00 : 8'he5);
    end
    $display("override test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
